//--- atd_top.sv
// Adaptive threshold detector control logic with register file
// Assumes conversion results arrive on MCLK_I with a one-cycle strobe
// How it works
// - Adaptive threshold sits sensitivity above, below or both around mean.
// - Adaptive hysteresis is a quarter of sensitivity, switchable by setup bit.
// - Constant threshold compares without hysteresis regardless of enable bit.
// - Expiry counting starts when result leaves mean plus or minus sensitivity.
// - On expiry the mean takes the newest result immediately.
// - Approaching and receding expiry lengths are programmed independently.
// - Offset source steps up above three quarters, down below one quarter.
// - Offset step size follows the selected input span.
// - Sleep timer forces power-down after quiet period without detection.
// - Power-down ends only on a serial configuration write or power cycle.
// - Supply low holds adaptive logic in reset.
// - After supply recovers, first conversion loads the mean.
// - Conversions and serial access continue during supply low.
// - Status bit 7 reports supply low or power-down.
// - Serial number bytes at 0x13 to 0x16, most significant first.
// - Constant threshold shares band and expiry register locations.
// - Expiry after two to the field power; zero register disables both.
`timescale 1ns/10ps
`default_nettype none
`include "atd_consts.svh"
module atd_top import atd_pkg::*; #(
  parameter int SLEEP_TICK_CYC = `ATD_SLEEP_TICK_CYC,
  parameter logic [31:0] SERIAL_NUMBER = 32'h1357_9BDF, // Arbitrary
  parameter logic [7:0] PART_ID = 8'h5A, // Arbitrary
  parameter logic [6:0] I2C_ADDR = `ATD_I2C_ADDR
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic CONV_DONE_I,
  input wire logic [11:0] CONV_DATA_I,
  input wire logic SUPPLY_LOW_I,
  output logic DETECT_O,
  output logic [5:0] OFFSET_DAC_O,
  output logic OFFSET_DAC_EN_O,
  output logic [1:0] INPUT_SPAN_O,
  output logic [2:0] OP_MODE_O,
  output logic CONV_RUN_O,
  output logic SLEEP_O
);
  atd_reg_req_t req;
  logic busy;
  logic [7:0] rdata;
  logic [1:0] sup_sy;
  logic supply_low;
  logic [7:0] band, tmo, setup, cfg, sleep_dly, dac;
  logic [11:0] result;
  logic [27:0] acc;
  logic [11:0] mean;
  logic load_first, rdy, dac_moved_n, sleeping, data_lock;
  logic adaptive, hyst_en, upd, dir_q, expire, appr, rec, next_detect;
  atd_limit_mode_t mode;
  logic signed [13:0] d, m, s, h, hi_set, lo_set;
  logic above_set, above_clr, below_set, below_clr, in_set, in_wide;
  logic [11:0] limit;
  logic cfg_wr, mean_hi, mean_lo, dac_up, dac_dn;
  logic [5:0] dac_step;
  logic signed [28:0] diff, delta;
  logic [4:0] shift;
  logic [31:0] tick_cnt;
  logic [5:0] quiet;
  logic tick;

  // Supply monitor level, two-stage synchroniser
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sup_sy <= 2'b00;
    end else begin
      sup_sy <= {sup_sy[0], SUPPLY_LOW_I};
    end
  end
  assign supply_low = sup_sy[1];

  atd_i2c_slave #(.DEV_ADDR(I2C_ADDR)) u_i2c (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .sda_oe_o(SDA_OE_O),
    .rdata_i(rdata),
    .req_o(req),
    .busy_o(busy)
  );
  assign SDA_O = 1'b0;

  // Host-written registers
  assign cfg_wr = req.wr && req.addr == `ATD_OFS_CFG;
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      band <= `ATD_RST_BAND;
      tmo <= `ATD_RST_TMO;
      setup <= `ATD_RST_SETUP;
      cfg <= `ATD_RST_CFG;
      sleep_dly <= `ATD_RST_SLEEP;
    end else if (req.wr) begin
      // One storage pair, meaning set by threshold mode
      if (req.addr == `ATD_OFS_BAND) begin
        band <= req.wdata;
      end else if (req.addr == `ATD_OFS_TMO) begin
        tmo <= req.wdata;
      end else if (req.addr == `ATD_OFS_SETUP) begin
        setup <= req.wdata;
      end else if (cfg_wr) begin
        cfg <= req.wdata;
      end else if (req.addr == `ATD_OFS_SLEEP) begin
        sleep_dly <= req.wdata;
      end
    end
  end

  // Comparator arithmetic
  assign mean = acc[27:16];
  assign adaptive = !cfg[`ATD_CFG_CONST];
  assign mode = atd_limit_mode_t'(cfg[6:5]);
  assign hyst_en = setup[`ATD_SETUP_HYST];
  assign d = {2'b00, CONV_DATA_I};
  assign m = {2'b00, mean};
  assign s = {6'h00, band};
  assign h = hyst_en ? {8'h00, band[7:2]} : 14'sh0000;
  assign hi_set = m + s;
  assign lo_set = m - s;
  assign above_set = d > hi_set;
  assign below_set = d < lo_set;
  assign above_clr = d > hi_set - h;
  assign below_clr = d < lo_set + h;
  assign in_set = !above_set && !below_set;
  assign in_wide = (d <= hi_set + h) && (d >= lo_set - h);
  assign limit = {band, tmo[7:4]};

  always_comb begin
    next_detect = 1'b0;
    if (!adaptive) begin
      // Plain compare, hysteresis never applied
      next_detect = cfg[5] ? (CONV_DATA_I > limit) : (CONV_DATA_I < limit);
    end else begin
      case (mode)
        // Release needs a move back by hysteresis
        ATD_LIM_POS: next_detect = DETECT_O ? above_clr : above_set;
        ATD_LIM_NEG: next_detect = DETECT_O ? below_clr : below_set;
        ATD_LIM_INWIN: next_detect = DETECT_O ? in_wide : in_set;
        default: next_detect = DETECT_O ? (above_clr || below_clr)
                                        : !in_set;
      endcase
    end
  end

  // Direction of band exit relative to the threshold
  always_comb begin
    appr = !in_set;
    rec = 1'b0;
    if (mode == ATD_LIM_POS) begin
      appr = above_set;
      rec = below_set;
    end else if (mode == ATD_LIM_NEG) begin
      appr = below_set;
      rec = above_set;
    end
  end

  assign upd = CONV_DONE_I && !supply_low;

  // Band exit starts counting; zero register disables
  atd_expiry_counter #(.W(16)) u_expiry (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .clear_i(supply_low || (CONV_DONE_I && rec != dir_q)),
    .step_i(upd && adaptive && !load_first),
    .active_i(appr || rec),
    .enable_i(tmo != 8'h00),
    .exp_i(rec ? tmo[3:0] : tmo[7:4]),
    .expire_o(expire)
  );

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dir_q <= 1'b0;
    end else if (CONV_DONE_I) begin
      dir_q <= rec;
    end
  end

  // Output comparator, held off while supply is low in adaptive mode only
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      DETECT_O <= 1'b0;
    end else if (supply_low && adaptive) begin
      DETECT_O <= 1'b0;
    end else if (CONV_DONE_I) begin
      DETECT_O <= (adaptive && load_first) ? 1'b0 : next_detect;
    end
  end

  // Running mean with programmable settling
  assign shift = {1'b0, setup[3:0]} + 5'h01;
  assign diff = $signed({1'b0, CONV_DATA_I, 16'h0000})
              - $signed({1'b0, acc});
  assign delta = diff >>> shift;
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      acc <= 28'h0000000;
      load_first <= 1'b1;
    end else if (supply_low) begin
      acc <= 28'h0000000;
      load_first <= 1'b1;
    end else if (CONV_DONE_I) begin
      load_first <= 1'b0;
      if (load_first || expire) begin
        acc <= {CONV_DATA_I, 16'h0000};
      end else begin
        acc <= acc + 28'(delta);
      end
    end
  end

  // Conversion result and ready flag, kept running in supply low
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      data_lock <= 1'b0;
    end else if (req.rd && (req.addr == `ATD_OFS_RES_HI
                         || req.addr == `ATD_OFS_RES_LO)) begin
      data_lock <= 1'b1;
    end else if (!busy) begin
      data_lock <= 1'b0;
    end
  end
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      result <= 12'h000;
    end else if (CONV_DONE_I && !data_lock) begin
      result <= CONV_DATA_I;
    end
  end
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdy <= 1'b1;
    end else if (CONV_DONE_I && !data_lock) begin
      rdy <= 1'b0;
    end else if (req.rd && (req.addr == `ATD_OFS_RES_HI
                         || req.addr == `ATD_OFS_RES_LO)) begin
      rdy <= 1'b1;
    end
  end

  // Automatic offset source tracking
  assign mean_hi = mean > `ATD_MEAN_UPPER;
  assign mean_lo = mean < `ATD_MEAN_LOWER;
  assign dac_step = 6'h01 << setup[7:6];
  assign dac_up = upd && adaptive && !load_first && dac[`ATD_DAC_TRACK]
                && mean_hi && dac[5:0] != `ATD_DAC_MAX;
  assign dac_dn = upd && adaptive && !load_first && dac[`ATD_DAC_TRACK]
                && mean_lo && dac[5:0] != 6'h00;
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dac <= `ATD_RST_DAC;
    end else if (req.wr && req.addr == `ATD_OFS_DAC) begin
      dac <= req.wdata;
    end else if (dac_up) begin
      // Saturating step up
      dac[5:0] <= (`ATD_DAC_MAX - dac[5:0] < dac_step) ? `ATD_DAC_MAX
                : dac[5:0] + dac_step;
    end else if (dac_dn) begin
      dac[5:0] <= (dac[5:0] < dac_step) ? 6'h00
                : dac[5:0] - dac_step;
    end
  end
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dac_moved_n <= 1'b1;
    end else if (CONV_DONE_I) begin
      dac_moved_n <= !(dac_up || dac_dn);
    end
  end

  // Sleep timer: ticks counted while detection stays quiet
  assign tick = tick_cnt == 32'(SLEEP_TICK_CYC - 1);
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tick_cnt <= 32'h00000000;
    end else if (tick || DETECT_O || sleeping) begin
      tick_cnt <= 32'h00000000;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      quiet <= 6'h00;
    end else if (DETECT_O || cfg_wr || sleeping) begin
      quiet <= 6'h00;
    end else if (tick) begin
      quiet <= quiet + 6'h01;
    end
  end
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sleeping <= 1'b0;
    end else if (sleep_dly[5:0] != 6'h00 && quiet == sleep_dly[5:0]
                 && !DETECT_O) begin
      sleeping <= 1'b1;
    end else if (cfg_wr) begin
      sleeping <= 1'b0;
    end
  end

  // Registered control outputs
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CONV_RUN_O <= 1'b0;
      SLEEP_O <= 1'b0;
    end else begin
      CONV_RUN_O <= cfg[`ATD_CFG_RUN] && !sleeping;
      SLEEP_O <= sleeping;
    end
  end
  assign OFFSET_DAC_O = dac[5:0];
  assign OFFSET_DAC_EN_O = dac[`ATD_DAC_EN];
  assign INPUT_SPAN_O = setup[7:6];
  assign OP_MODE_O = cfg[2:0];

  // Register read decode
  always_comb begin
    rdata = 8'h00;
    if (req.addr == `ATD_OFS_STATUS) begin
      rdata = {supply_low || sleeping, 2'b10, dac_moved_n,
               DETECT_O, 2'b01, rdy};
    end else if (req.addr == `ATD_OFS_RES_HI) begin
      rdata = result[11:4];
    end else if (req.addr == `ATD_OFS_RES_LO) begin
      rdata = {result[3:0], 4'h0};
    end else if (req.addr == `ATD_OFS_MEAN_HI) begin
      rdata = mean[11:4];
    end else if (req.addr == `ATD_OFS_MEAN_LO) begin
      rdata = {mean[3:0], 4'h0};
    end else if (req.addr == `ATD_OFS_BAND) begin
      rdata = band;
    end else if (req.addr == `ATD_OFS_TMO) begin
      rdata = tmo;
    end else if (req.addr == `ATD_OFS_SETUP) begin
      rdata = setup;
    end else if (req.addr == `ATD_OFS_CFG) begin
      rdata = cfg;
    end else if (req.addr == `ATD_OFS_SLEEP) begin
      rdata = sleep_dly;
    end else if (req.addr == `ATD_OFS_DAC) begin
      rdata = dac;
    end else if (req.addr == `ATD_OFS_SER3) begin
      rdata = SERIAL_NUMBER[31:24];
    end else if (req.addr == `ATD_OFS_SER2) begin
      rdata = SERIAL_NUMBER[23:16];
    end else if (req.addr == `ATD_OFS_SER1) begin
      rdata = SERIAL_NUMBER[15:8];
    end else if (req.addr == `ATD_OFS_SER0) begin
      rdata = SERIAL_NUMBER[7:0];
    end else if (req.addr == `ATD_OFS_PART) begin
      rdata = PART_ID;
    end
  end

  // Checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  a_adapt_pos_set: assert property (CONV_DONE_I && !supply_low && adaptive
    && !load_first && mode == ATD_LIM_POS && above_set |=> DETECT_O)
    else $error("adaptive positive crossing missed");
  a_hyst_hold: assert property (CONV_DONE_I && !supply_low && adaptive
    && !load_first && mode == ATD_LIM_POS && DETECT_O && hyst_en
    && d > hi_set - {8'h00, band[7:2]} |=> DETECT_O)
    else $error("hysteresis released output too early");
  a_fixed_plain: assert property (CONV_DONE_I && !adaptive && cfg[5]
    && CONV_DATA_I <= limit |=> !DETECT_O)
    else $error("constant mode held output");
  a_expiry_load: assert property (expire && !supply_low
    |=> mean == $past(CONV_DATA_I))
    else $error("mean not loaded on expiry");
  a_expiry_off: assert property (tmo == 8'h00 |-> !expire)
    else $error("expiry while disabled");
  a_dac_up: assert property (dac_up && !req.wr
    |=> dac[5:0] > $past(dac[5:0]))
    else $error("offset source did not step up");
  a_dac_down: assert property (dac_dn && !req.wr
    |=> dac[5:0] < $past(dac[5:0]))
    else $error("offset source did not step down");
  a_supply_hold: assert property (supply_low |=> load_first
    && acc == 28'h0000000)
    else $error("adaptive logic not held in reset");
  a_first_load: assert property (load_first && upd
    |=> mean == $past(CONV_DATA_I) && !load_first)
    else $error("first result not loaded");
  a_status_flag: assert property (supply_low && req.addr == 8'h00
    |-> rdata[7])
    else $error("supply flag not shown");
  a_sleep_wake: assert property (sleeping && cfg_wr && quiet == 6'h00
    |=> !sleeping ##1 !SLEEP_O)
    else $error("sleep output stayed after wake");
  c_detect: cover property (!DETECT_O ##1 DETECT_O);
  c_expire: cover property (expire);
  c_dac_step: cover property (dac_up || dac_dn);
  c_sleep: cover property (!SLEEP_O ##1 SLEEP_O);
endmodule
`default_nettype wire

//--- atd_consts.svh
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by the top, serial slave and host model files of the threshold detector
`ifndef ATD_CONSTS_SVH
`define ATD_CONSTS_SVH
`define ATD_OFS_STATUS 8'h00
`define ATD_OFS_RES_HI 8'h01
`define ATD_OFS_RES_LO 8'h02
`define ATD_OFS_MEAN_HI 8'h05
`define ATD_OFS_MEAN_LO 8'h06
`define ATD_OFS_BAND 8'h09
`define ATD_OFS_TMO 8'h0A
`define ATD_OFS_SETUP 8'h0B
`define ATD_OFS_CFG 8'h0F
`define ATD_OFS_SLEEP 8'h10
`define ATD_OFS_DAC 8'h11
`define ATD_OFS_SER3 8'h13
`define ATD_OFS_SER2 8'h14
`define ATD_OFS_SER1 8'h15
`define ATD_OFS_SER0 8'h16
`define ATD_OFS_PART 8'h17
`define ATD_RST_BAND 8'h08
`define ATD_RST_TMO 8'h86
`define ATD_RST_SETUP 8'h0B
`define ATD_RST_CFG 8'h11
`define ATD_RST_SLEEP 8'h00
`define ATD_RST_DAC 8'h80
`define ATD_SETUP_HYST 4
`define ATD_CFG_CONST 7
`define ATD_CFG_RUN 4
`define ATD_DAC_EN 7
`define ATD_DAC_TRACK 6
`define ATD_MEAN_UPPER 12'hC00
`define ATD_MEAN_LOWER 12'h400
`define ATD_DAC_MAX 6'h3F
`define ATD_CLK_HZ 50000000
`define ATD_SLEEP_TICK_US 1000
`define ATD_SLEEP_TICK_CYC (`ATD_SLEEP_TICK_US * (`ATD_CLK_HZ / 1000000))
`define ATD_I2C_ADDR 7'h48
`endif

//--- atd_pkg.sv
// Types shared by the threshold detector modules
// Assumes nothing beyond a SystemVerilog compiler
package atd_pkg;
  typedef enum logic [1:0] {
    ATD_LIM_NEG, ATD_LIM_POS, ATD_LIM_INWIN, ATD_LIM_OUTWIN
  } atd_limit_mode_t;
  typedef enum logic [2:0] {
    ATD_I2C_IDLE, ATD_I2C_ADDR, ATD_I2C_PTR, ATD_I2C_WR, ATD_I2C_RD
  } atd_i2c_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } atd_reg_req_t;
endpackage

//--- atd_expiry_counter.sv
// Conversion counter for approaching and receding expiry
// Assumes step_i is a one-cycle pulse per finished conversion
`timescale 1ns/10ps
`default_nettype none
module atd_expiry_counter #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic active_i,
  input wire logic enable_i,
  input wire logic [3:0] exp_i,
  output logic expire_o
);
  logic [W-1:0] cnt;
  logic [W-1:0] cnt_base;
  logic [W:0] goal;
  logic [W:0] cnt_next;
  // Direction change restarts the count with this conversion included
  assign cnt_base = clear_i ? '0 : cnt;
  assign goal = (W+1)'(1) << exp_i;
  assign cnt_next = {1'b0, cnt_base} + (W+1)'(1);
  // Expiry after two to the power of the field conversions
  assign expire_o = step_i && active_i && enable_i && (cnt_next >= goal);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else if (step_i) begin
      if (active_i && enable_i && !expire_o) begin
        cnt <= cnt_next[W-1:0];
      end else begin
        cnt <= '0;
      end
    end else if (clear_i) begin
      cnt <= '0;
    end
  end
endmodule
`default_nettype wire

//--- atd_i2c_slave.sv
// Two-wire serial slave with auto-incrementing register pointer
// Assumes open-drain bus with pull-ups; SCL and SDA are asynchronous
`timescale 1ns/10ps
`default_nettype none
`include "atd_consts.svh"
module atd_i2c_slave import atd_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = `ATD_I2C_ADDR
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  input wire logic [7:0] rdata_i,
  output atd_reg_req_t req_o,
  output logic busy_o
);
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic scl_q;
  logic sda_q;
  atd_i2c_state_t st;
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [3:0] cnt;
  logic in_ack;
  logic rise;
  logic fall;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], scl_i};
      sda_sy <= {sda_sy[0], sda_i};
      scl_q <= scl_sy[1];
      sda_q <= sda_sy[1];
    end
  end
  assign rise = scl_sy[1] && !scl_q;
  assign fall = !scl_sy[1] && scl_q;
  assign busy_o = (st != ATD_I2C_IDLE);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= ATD_I2C_IDLE;
      sh <= 8'h00;
      ptr <= 8'h00;
      cnt <= 4'h0;
      in_ack <= 1'b0;
      sda_oe_o <= 1'b0;
      req_o <= '0;
    end else begin
      req_o.wr <= 1'b0;
      req_o.rd <= 1'b0;
      // Address follows the pointer so read data is looked up ahead
      req_o.addr <= ptr;
      if (scl_q && sda_q && !sda_sy[1]) begin
        st <= ATD_I2C_ADDR;
        cnt <= 4'h0;
        in_ack <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (scl_q && !sda_q && sda_sy[1]) begin
        st <= ATD_I2C_IDLE;
        sda_oe_o <= 1'b0;
      end else if (rise && st != ATD_I2C_IDLE) begin
        if (in_ack) begin
          if (st == ATD_I2C_RD && sda_sy[1]) begin
            st <= ATD_I2C_IDLE;
          end
        end else begin
          if (st != ATD_I2C_RD) begin
            sh <= {sh[6:0], sda_sy[1]};
          end
          cnt <= cnt + 4'h1;
        end
      end else if (fall && st != ATD_I2C_IDLE) begin
        if (in_ack) begin
          in_ack <= 1'b0;
          cnt <= 4'h0;
          sda_oe_o <= 1'b0;
          if (st == ATD_I2C_RD) begin
            sh <= rdata_i;
            sda_oe_o <= !rdata_i[7];
            req_o.rd <= 1'b1;
            req_o.addr <= ptr;
            ptr <= ptr + 8'h01;
          end
        end else if (cnt == 4'h8) begin
          in_ack <= 1'b1;
          sda_oe_o <= 1'b1;
          case (st)
            ATD_I2C_ADDR: begin
              if (sh[7:1] == DEV_ADDR) begin
                st <= sh[0] ? ATD_I2C_RD : ATD_I2C_PTR;
              end else begin
                st <= ATD_I2C_IDLE;
                sda_oe_o <= 1'b0;
              end
            end
            ATD_I2C_PTR: begin
              ptr <= sh;
              st <= ATD_I2C_WR;
            end
            ATD_I2C_WR: begin
              req_o.wr <= 1'b1;
              req_o.addr <= ptr;
              req_o.wdata <= sh;
              ptr <= ptr + 8'h01;
            end
            default: begin
              sda_oe_o <= 1'b0;
            end
          endcase
        end else if (st == ATD_I2C_RD && cnt != 4'h0) begin
          sh <= {sh[6:0], 1'b0};
          sda_oe_o <= !sh[6];
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- atd_host_model.sv
// Two-wire bus master model that reaches the detector registers
// Assumes a pull-up on SDA; sda_i carries the wired bus level
`timescale 1ns/10ps
`default_nettype none
`include "atd_consts.svh"
module atd_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // One bus phase of six clocks, well above the minimum
  task automatic st(input logic c, input logic o);
    scl_o <= c;
    sda_oe_o <= o;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic start();
    st(scl_o, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
    st(1'b0, 1'b1);
  endtask
  task automatic stop();
    st(1'b0, 1'b1);
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
  endtask
  // Eight data bits then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic l,
                      output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      st(1'b0, ~d[i]);
      st(1'b1, ~d[i]);
      q[i] = sda_i;
      st(1'b0, ~d[i]);
    end
    st(1'b0, ~l);
    st(1'b1, ~l);
    st(1'b0, ~l);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    start();
    xfer({`ATD_I2C_ADDR, 1'b0}, 1'b1, q);
    xfer(p, 1'b1, q);
    xfer(d, 1'b1, q);
    stop();
  endtask
  // Reads n bytes from p upward, last byte refused to end the read
  task automatic rd(input logic [7:0] p, input int n,
                    output logic [31:0] v);
    logic [7:0] q;
    v = 32'h0;
    start();
    xfer({`ATD_I2C_ADDR, 1'b0}, 1'b1, q);
    xfer(p, 1'b1, q);
    start();
    xfer({`ATD_I2C_ADDR, 1'b1}, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, i == n - 1, q);
      v = {v[23:0], q};
    end
    stop();
  endtask
endmodule
`default_nettype wire

//--- adaptive_threshold_detector_tb.sv
// Self-checking bench for the threshold detector top
// Assumes the host model as bus master and a pull-up on SDA
`timescale 1ns/10ps
`default_nettype none
module adaptive_threshold_detector_tb;
  localparam logic [31:0] SER = 32'h2468ACE1; // Arbitrary
  localparam logic [7:0] PID = 8'hA5; // Arbitrary
  logic mclk, resetn, scl, host_oe, dut_oe, sda_o, conv_done, supply_low;
  logic detect, dac_en, run, sleep;
  logic [11:0] conv_data;
  logic [5:0] dac;
  logic [1:0] span;
  logic [2:0] mode;
  wire logic sda_line;
  int bad_count, total_checks, cycles;
  logic [31:0] v;
  assign sda_line = ~(host_oe | dut_oe);
  atd_top #(.SLEEP_TICK_CYC(20), .SERIAL_NUMBER(SER), .PART_ID(PID)) i_dut (
    .MCLK_I(mclk), .RESETN_I(resetn), .SCL_I(scl), .SDA_I(sda_line),
    .SDA_O(sda_o), .SDA_OE_O(dut_oe), .CONV_DONE_I(conv_done),
    .CONV_DATA_I(conv_data), .SUPPLY_LOW_I(supply_low), .DETECT_O(detect),
    .OFFSET_DAC_O(dac), .OFFSET_DAC_EN_O(dac_en), .INPUT_SPAN_O(span),
    .OP_MODE_O(mode), .CONV_RUN_O(run), .SLEEP_O(sleep));
  atd_host_model i_host (.clk_i(mclk), .sda_i(sda_line), .scl_o(scl),
    .sda_oe_o(host_oe));
  always #10 mclk = ~mclk;
  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic do_reset(input logic [7:0] cfg, input logic [7:0] su);
    resetn <= 1'b0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    i_host.wr(8'h0F, cfg);
    i_host.wr(8'h0B, su);
  endtask
  task automatic conv(input logic [11:0] d);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge mclk);
    conv_done <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_regs();
    logic [15:0] t [8] = '{16'h0908, 16'h0A86, 16'h0B0B, 16'h0F11,
      16'h1000, 16'h1180, 16'h0053, 16'h0300};
    do_reset(8'h11, 8'h0B);
    foreach (t[i]) begin
      i_host.rd(t[i][15:8], 1, v);
      check("reset value", v, {24'h0, t[i][7:0]});
    end
    i_host.wr(8'h13, 8'h00);
    i_host.rd(8'h13, 4, v);
    check("serial number", v, SER);
    check("serial drive level", sda_o, 1'b0);
    $display("test regs done");
  endtask
  task automatic t_hyst();
    do_reset(8'h31, 8'h1F);
    i_host.wr(8'h09, 8'h20);
    i_host.wr(8'h0A, 8'h00);
    conv(12'h800);
    conv(12'h830);
    check("above band", detect, 1'b1);
    conv(12'h81A);
    check("inside hysteresis", detect, 1'b1);
    conv(12'h810);
    check("released", detect, 1'b0);
    i_host.wr(8'h0B, 8'h0F);
    conv(12'h830);
    conv(12'h81A);
    check("hysteresis off", detect, 1'b0);
    $display("test hysteresis done");
  endtask
  task automatic t_const();
    do_reset(8'hB1, 8'h1F);
    i_host.wr(8'h09, 8'h90);
    i_host.wr(8'h0A, 8'h00);
    conv(12'h800);
    conv(12'h910);
    check("constant above", detect, 1'b1);
    conv(12'h8FE);
    check("constant no hyst", detect, 1'b0);
    $display("test constant done");
  endtask
  task automatic t_tmo();
    logic [11:0] d [5] = '{12'h900, 12'h900, 12'h900, 12'h800, 12'h800};
    logic [7:0] e [5] = '{8'h80, 8'h80, 8'h90, 8'h8F, 8'h80};
    do_reset(8'h31, 8'h0F);
    i_host.wr(8'h0A, 8'h21);
    conv(12'h800);
    conv(12'h900);
    foreach (d[i]) begin
      conv(d[i]);
      i_host.rd(8'h05, 1, v);
      check("mean after expiry", v, {24'h0, e[i]});
    end
    $display("test expiry done");
  endtask
  task automatic t_dac();
    do_reset(8'h31, 8'h4F);
    i_host.wr(8'h11, 8'hD0);
    conv(12'hD00);
    v = {26'h0, dac};
    conv(12'hD00);
    check("offset step", 6'(dac - v[5:0]), 6'h02);
    check("offset enable and span", {dac_en, span}, 3'b101);
    $display("test offset done");
  endtask
  task automatic t_sleep();
    do_reset(8'h11, 8'h0B);
    i_host.wr(8'h10, 8'h3F);
    i_host.wr(8'h0F, 8'h11); // Restart the quiet period
    repeat (1000) @(posedge mclk);
    check("awake early", sleep, 1'b0);
    repeat (400) @(posedge mclk);
    check("asleep", sleep, 1'b1);
    check("run stopped", run, 1'b0);
    i_host.rd(8'h00, 1, v);
    check("status asleep", v[7], 1'b1);
    i_host.wr(8'h0F, 8'h11); // Wake command
    check("woken", sleep, 1'b0);
    check("mode and run", {mode, run}, 4'h3);
    $display("test sleep done");
  endtask
  task automatic t_supply();
    do_reset(8'h31, 8'h0F);
    conv(12'h800);
    supply_low <= 1'b1;
    repeat (4) @(posedge mclk);
    conv(12'h900);
    check("detect held", detect, 1'b0);
    i_host.rd(8'h00, 2, v); // Result read here still follows conversions
    check("low flag and data", {v[15], v[7:0]}, 9'h190);
    supply_low <= 1'b0;
    repeat (4) @(posedge mclk);
    conv(12'hA00);
    i_host.rd(8'h05, 1, v);
    check("mean reload", v, 32'hA0);
    $display("test supply done");
  endtask
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    conv_done = 1'b0;
    conv_data = 12'h000;
    supply_low = 1'b0;
    t_regs();
    t_hyst();
    t_const();
    t_tmo();
    t_dac();
    t_sleep();
    t_supply();
    print_verdict();
  end
endmodule
`default_nettype wire
